// ===== logic/ecd_core.sv
// central processor datapath: sequencing, decode, control, alu, scratch pad,
// accumulator and multiplier/quotient register.
// assumes program memory answers pm_addr with pm_word in the same cycle.
`timescale 1ns/100ps
`default_nettype none
`include "ecd_defs.svh"

module ecd_core
  import ecd_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // program memory
  output logic [`ECD_PC_W-1:0] pm_addr,
  input wire ecd_word_s pm_word,
  // pins from outside the clock domain
  input wire logic sensor_ser_in,
  input wire logic cmd_ser_in,
  input wire logic ad_done_in,
  // control strobes
  output logic pc_adv,
  output logic ad_start,
  output logic ser_shift,
  output logic [3:0] ser_bit_idx,
  // data and status
  output ecd_data_t da_out,
  output logic [`ECD_OUTC_W-1:0] out_addr,
  output logic [`ECD_INC_W-1:0] in_cnt,
  output ecd_data_t acc_q,
  output ecd_data_t mq_q,
  output ecd_instr_e cur_instr
);

  // --------------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------------
  logic [2:0] pin_in;
  logic [2:0] sy1_ff, sy2_ff, sy3_ff, pin_ff;
  assign pin_in = {ad_done_in, cmd_ser_in, sensor_ser_in};
  // a change counts only once stages two and three agree
  for (genvar k = 0; k < 3; k++) begin : g_sync
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        sy1_ff[k] <= 1'b0;
        sy2_ff[k] <= 1'b0;
        sy3_ff[k] <= 1'b0;
        pin_ff[k] <= 1'b0;
      end else if (ce) begin
        sy1_ff[k] <= pin_in[k];
        sy2_ff[k] <= sy1_ff[k];
        sy3_ff[k] <= sy2_ff[k];
        if (sy2_ff[k] == sy3_ff[k]) begin
          pin_ff[k] <= sy2_ff[k];
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // op-code decode
  // --------------------------------------------------------------------------
  ecd_state_e state_ff;
  ecd_instr_e instr_ff;
  logic [3:0] bit_cnt_ff;
  logic [`ECD_PC_W-1:0] pc_ff;
  logic [3:0] ocode;
  logic in_decode;
  logic restart;
  assign pm_addr = pc_ff;
  assign ocode = pm_word.operand[`ECD_OCODE_HI:`ECD_OCODE_LO];
  always_comb begin
    cur_instr = ecd_i_nop;
    case (pm_word.op)
      `ECD_OP_OUT: begin
        if (ocode == `ECD_OUT_LOAD) begin
          cur_instr = ecd_i_out_load;
        end else if (ocode >= `ECD_OUT_ADDR_LO && ocode <= `ECD_OUT_ADDR_HI) begin
          cur_instr = ecd_i_out_addr;
        end else if (ocode == `ECD_OUT_AD) begin
          cur_instr = ecd_i_out_ad;
        end else if (ocode == `ECD_OUT_RESTART) begin
          cur_instr = ecd_i_restart;
        end
      end
      `ECD_OP_INPS: cur_instr = ecd_i_inp_sensor;
      `ECD_OP_INPC: cur_instr = ecd_i_inp_cmd;
      `ECD_OP_LAI: cur_instr = ecd_i_lai;
      `ECD_OP_LMI: cur_instr = ecd_i_lmi;
      `ECD_OP_ALU_AR, `ECD_OP_ALU_ARC, `ECD_OP_ALU_LG: cur_instr = ecd_i_alu;
      `ECD_OP_STA: cur_instr = ecd_i_sta;
      `ECD_OP_SHL: cur_instr = ecd_i_shl;
      `ECD_OP_SHR: cur_instr = ecd_i_shr;
      default: cur_instr = ecd_i_nop;
    endcase
  end
  assign in_decode = (state_ff == ecd_st_decode);
  assign restart = in_decode && (cur_instr == ecd_i_restart);

  // --------------------------------------------------------------------------
  // control sequencer
  // --------------------------------------------------------------------------
  logic serial_op;
  assign serial_op = (cur_instr == ecd_i_inp_sensor) || (cur_instr == ecd_i_inp_cmd) ||
                     (cur_instr == ecd_i_lai) || (cur_instr == ecd_i_lmi);
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_ff <= ecd_st_decode;
      instr_ff <= ecd_i_nop;
      bit_cnt_ff <= 4'h0;
    end else if (ce) begin
      case (state_ff)
        ecd_st_decode: begin
          instr_ff <= cur_instr;
          bit_cnt_ff <= 4'h0;
          if (restart) begin
            state_ff <= ecd_st_decode;
          end else if (serial_op) begin
            state_ff <= ecd_st_serial;
          end else begin
            state_ff <= ecd_st_done;
          end
        end
        ecd_st_serial: begin
          bit_cnt_ff <= bit_cnt_ff + 4'h1;
          if (bit_cnt_ff == `ECD_SER_LAST) begin
            state_ff <= ecd_st_done;
          end
        end
        ecd_st_done: state_ff <= ecd_st_decode;
        default: state_ff <= ecd_st_decode;
      endcase
    end
  end
  assign pc_adv = (state_ff == ecd_st_done);
  assign ser_shift = (state_ff == ecd_st_serial);
  assign ser_bit_idx = bit_cnt_ff;
  assign ad_start = in_decode && (cur_instr == ecd_i_out_ad);

  // --------------------------------------------------------------------------
  // counters
  // --------------------------------------------------------------------------
  logic ad_prev_ff;
  // restart wins over every advance in the same cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pc_ff <= `ECD_PC_RST;
      out_addr <= `ECD_OUTC_RST;
      in_cnt <= `ECD_INC_RST;
      ad_prev_ff <= 1'b0;
    end else if (ce) begin
      ad_prev_ff <= pin_ff[2];
      if (restart) begin
        pc_ff <= `ECD_PC_RST;
        out_addr <= `ECD_OUTC_RST;
        in_cnt <= `ECD_INC_RST;
      end else begin
        if (pc_adv) begin
          pc_ff <= pc_ff + 12'h001;
        end
        if (in_decode && cur_instr == ecd_i_out_addr) begin
          out_addr <= out_addr + 3'h1;
        end
        if (pin_ff[2] && !ad_prev_ff) begin
          in_cnt <= in_cnt + 5'h01;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // scratch pad and alu
  // --------------------------------------------------------------------------
  ecd_data_t sp_mem [`ECD_SP_DEPTH];
  ecd_data_t acc_ff, mq_ff, sp_b, alu_f;
  ecd_alu_ctl_s alu_ctl;
  logic [`ECD_SP_AW-1:0] sp_addr;
  logic sp_rd_en, sp_wr;
  assign sp_addr = pm_word.operand[`ECD_SPA_HI:`ECD_SPA_LO];
  assign sp_rd_en = (cur_instr == ecd_i_alu);
  assign sp_wr = in_decode && (cur_instr == ecd_i_sta) && !sp_rd_en;
  assign sp_b = sp_rd_en ? sp_mem[sp_addr] : `ECD_DATA_RST;
  for (genvar g = 0; g < `ECD_SP_DEPTH; g++) begin : g_pad
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        sp_mem[g] <= `ECD_DATA_RST;
      end else if (ce && sp_wr && sp_addr == 8'(g)) begin
        sp_mem[g] <= acc_ff;
      end
    end
  end
  assign alu_ctl.sel = pm_word.operand[`ECD_SEL_HI:`ECD_SEL_LO];
  assign alu_ctl.mode = (pm_word.op == `ECD_OP_ALU_LG);
  assign alu_ctl.cin = (pm_word.op == `ECD_OP_ALU_ARC);
  ecd_alu ecd_alu_inst (
    .a(acc_ff),
    .b(sp_b),
    .ctl(alu_ctl),
    .f(alu_f)
  );

  // --------------------------------------------------------------------------
  // accumulator and multiplier/quotient register
  // --------------------------------------------------------------------------
  logic ser_bit;
  always_comb begin
    case (instr_ff)
      ecd_i_inp_sensor: ser_bit = pin_ff[0];
      ecd_i_inp_cmd: ser_bit = pin_ff[1];
      default: ser_bit = pm_word.operand[bit_cnt_ff];
    endcase
  end
  // lsb arrives first, so the serial load shifts right
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      acc_ff <= `ECD_DATA_RST;
    end else if (ce) begin
      if (in_decode) begin
        case (cur_instr)
          ecd_i_alu: acc_ff <= alu_f;
          ecd_i_lmi: acc_ff <= `ECD_DATA_RST;
          ecd_i_shl: acc_ff <= {acc_ff[10:0], mq_ff[11]};
          ecd_i_shr: acc_ff <= {mq_ff[0], acc_ff[11:1]};
          default: acc_ff <= acc_ff;
        endcase
      end else if (ser_shift && instr_ff != ecd_i_lmi) begin
        acc_ff <= {ser_bit, acc_ff[11:1]};
      end
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mq_ff <= `ECD_DATA_RST;
    end else if (ce) begin
      if (in_decode && cur_instr == ecd_i_shl) begin
        mq_ff <= {mq_ff[10:0], acc_ff[11]};
      end else if (in_decode && cur_instr == ecd_i_shr) begin
        mq_ff <= {acc_ff[0], mq_ff[11:1]};
      end else if (ser_shift && instr_ff == ecd_i_lmi) begin
        mq_ff <= {ser_bit, mq_ff[11:1]};
      end
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      da_out <= `ECD_DATA_RST;
    end else if (ce && in_decode && cur_instr == ecd_i_out_load) begin
      da_out <= acc_ff;
    end
  end
  assign acc_q = acc_ff;
  assign mq_q = mq_ff;

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  logic [3:0] pulse_cnt_ff;
  logic was_serial;
  // helper counter obeys ce like all other state
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pulse_cnt_ff <= 4'h0;
    end else if (ce && in_decode) begin
      pulse_cnt_ff <= 4'h0;
    end else if (ce && ser_shift) begin
      pulse_cnt_ff <= pulse_cnt_ff + 4'h1;
    end
  end
  assign was_serial = (instr_ff == ecd_i_inp_sensor) || (instr_ff == ecd_i_inp_cmd) ||
                      (instr_ff == ecd_i_lai) || (instr_ff == ecd_i_lmi);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  pc_step_a: assert property (pc_adv && ce |=> pc_ff == $past(pc_ff) + 12'h001)
    else $error("pc did not advance");
  pc_hold_a: assert property (!pc_adv && !restart |=> pc_ff == $past(pc_ff))
    else $error("pc moved without advance");
  restart_clr_a: assert property (restart && ce |=> pc_ff == 12'h000 && out_addr == 3'h0
    && in_cnt == 5'h00 && in_decode)
    else $error("restart left a counter set");
  simple_adv_a: assert property (in_decode && ce && !serial_op && !restart |=> pc_adv)
    else $error("single cycle instruction not advanced");
  alu_add_a: assert property (alu_ctl == {4'b1001, 1'b0, 1'b0} |-> alu_f == 12'(acc_ff + sp_b))
    else $error("alu add wrong");
  alu_sub_a: assert property (alu_ctl == {4'b0110, 1'b0, 1'b0}
    |-> alu_f == 12'(acc_ff - sp_b - 12'h001))
    else $error("alu subtract wrong");
  alu_dbl_a: assert property (alu_ctl == {4'b1100, 1'b0, 1'b0} |-> alu_f == {acc_ff[10:0], 1'b0})
    else $error("alu double wrong");
  alu_passb_a: assert property (alu_ctl.sel == 4'b1010 && alu_ctl.mode |-> alu_f == sp_b)
    else $error("alu logic pass wrong");
  alu_load_a: assert property (in_decode && ce && cur_instr == ecd_i_alu
    |=> acc_ff == $past(alu_f))
    else $error("accumulator missed alu result");
  pad_write_a: assert property (sp_wr && ce |=> sp_mem[$past(sp_addr)] == $past(acc_ff))
    else $error("scratch pad write lost");
  burst_len_a: assert property (pc_adv && was_serial |-> pulse_cnt_ff == `ECD_SER_PULSES)
    else $error("serial burst not twelve pulses");
  lai_val_a: assert property (pc_adv && instr_ff == ecd_i_lai |-> acc_ff == pm_word.operand)
    else $error("constant load wrong");
  lmi_val_a: assert property (pc_adv && instr_ff == ecd_i_lmi
    |-> mq_ff == pm_word.operand && acc_ff == 12'h000)
    else $error("mq constant load wrong");
  rot_left_a: assert property (in_decode && ce && cur_instr == ecd_i_shl
    |=> acc_ff == {$past(acc_ff[10:0]), $past(mq_ff[11])})
    else $error("left shift wrong");
  restart_c: cover property (restart && ce);
  lai_done_c: cover property (pc_adv && instr_ff == ecd_i_lai);
  lmi_done_c: cover property (pc_adv && instr_ff == ecd_i_lmi);
  alu_add_c: cover property (in_decode && ce && alu_ctl == {4'b1001, 1'b0, 1'b0});

endmodule

`default_nettype wire

// ===== logic/ecd_defs.svh
// constants of the engine control datapath: widths, opcodes, field positions,
// reset values and sequence counts; assumes it is included by bare name.
`ifndef ECD_DEFS_SVH
`define ECD_DEFS_SVH

// --------------------------------------------------------------------------
// widths and sizes
// --------------------------------------------------------------------------
`define ECD_W 12
`define ECD_PC_W 12
`define ECD_SP_AW 8
`define ECD_SP_DEPTH 256
`define ECD_OUTC_W 3
`define ECD_INC_W 5

// --------------------------------------------------------------------------
// program word fields
// --------------------------------------------------------------------------
`define ECD_SEL_HI 11
`define ECD_SEL_LO 8
`define ECD_SPA_HI 7
`define ECD_SPA_LO 0
`define ECD_OCODE_HI 3
`define ECD_OCODE_LO 0

// --------------------------------------------------------------------------
// opcodes and output sub-codes
// --------------------------------------------------------------------------
`define ECD_OP_OUT 4'h0
`define ECD_OP_INPS 4'h1
`define ECD_OP_INPC 4'h2
`define ECD_OP_LAI 4'h3
`define ECD_OP_LMI 4'h4
`define ECD_OP_ALU_AR 4'h5
`define ECD_OP_ALU_ARC 4'h6
`define ECD_OP_ALU_LG 4'h7
`define ECD_OP_STA 4'h8
`define ECD_OP_SHL 4'h9
`define ECD_OP_SHR 4'ha
`define ECD_OUT_LOAD 4'h1
`define ECD_OUT_ADDR_LO 4'h2
`define ECD_OUT_ADDR_HI 4'h6
`define ECD_OUT_AD 4'he
`define ECD_OUT_RESTART 4'hf

// --------------------------------------------------------------------------
// reset values and counts
// --------------------------------------------------------------------------
`define ECD_DATA_RST 12'h000
`define ECD_PC_RST 12'h000
`define ECD_OUTC_RST 3'h0
`define ECD_INC_RST 5'h00
`define ECD_SER_LAST 4'hb
`define ECD_SER_PULSES 4'hc

`endif

// ===== logic/ecd_pkg.sv
// types of the engine control datapath
// assumes ecd_defs.svh sits on the include path
`default_nettype none
`include "ecd_defs.svh"

package ecd_pkg;

  typedef logic [`ECD_W-1:0] ecd_data_t;

  typedef struct packed {
    logic [3:0] op;
    logic [`ECD_W-1:0] operand;
  } ecd_word_s;

  // sel[3] is s0, so 4'b1001 reads as HLLH
  typedef struct packed {
    logic [3:0] sel;
    logic mode;
    logic cin;
  } ecd_alu_ctl_s;

  typedef enum logic [3:0] {
    ecd_i_nop, ecd_i_out_load, ecd_i_out_addr, ecd_i_out_ad, ecd_i_restart,
    ecd_i_inp_sensor, ecd_i_inp_cmd, ecd_i_lai, ecd_i_lmi, ecd_i_alu,
    ecd_i_sta, ecd_i_shl, ecd_i_shr
  } ecd_instr_e;

  typedef enum logic [1:0] {
    ecd_st_decode, ecd_st_serial, ecd_st_done
  } ecd_state_e;

endpackage

`default_nettype wire

// ===== logic/ecd_alu.sv
// sixteen-function alu, active-high table, arithmetic or logic by mode
// assumes operands and control settle within one processor clock
`timescale 1ns/100ps
`default_nettype none

module ecd_alu
  import ecd_pkg::*;
(
  // operands
  input wire ecd_data_t a,
  input wire ecd_data_t b,
  // function
  input wire ecd_alu_ctl_s ctl,
  // result
  output ecd_data_t f
);

  // --------------------------------------------------------------------------
  // function table
  // --------------------------------------------------------------------------
  ecd_data_t x;
  ecd_data_t y;
  ecd_data_t lg;
  ecd_data_t cx;

  always_comb begin
    x = a;
    y = '0;
    lg = a;
    case (ctl.sel)
      4'b0000: begin y = '0;             lg = ~a;         end
      4'b0001: begin x = a | b;          lg = ~(a | b);   end
      4'b0010: begin x = a | ~b;         lg = ~a & b;     end
      4'b0011: begin x = '1;             lg = '0;         end
      4'b0100: begin y = a & ~b;         lg = ~(a & b);   end
      4'b0101: begin x = a | b; y = a & ~b; lg = ~b;     end
      4'b0110: begin y = ~b;             lg = a ^ b;      end
      4'b0111: begin x = a & ~b; y = '1; lg = a & ~b;    end
      4'b1000: begin y = a & b;          lg = ~a | b;     end
      4'b1001: begin y = b;              lg = ~(a ^ b);   end
      4'b1010: begin x = a | ~b; y = a & b; lg = b;      end
      4'b1011: begin x = a & b; y = '1;  lg = a & b;      end
      4'b1100: begin y = a;              lg = '1;         end
      4'b1101: begin x = a | b; y = a;   lg = a | ~b;     end
      4'b1110: begin x = a | ~b; y = a;  lg = a | b;      end
      default: begin y = '1;             lg = a;          end
    endcase
    cx = ecd_data_t'({11'h000, ctl.cin});
  end

  // carry ignored in logic mode
  assign f = ctl.mode ? lg : ecd_data_t'(x + y + cx);

endmodule

`default_nettype wire

// ===== test/ecd_pm_model.sv
// program memory model standing at the core's fetch port
// assumes the bench fills mem before releasing reset; unset words are nops
`timescale 1ns/100ps
`default_nettype none
`include "ecd_defs.svh"

module ecd_pm_model
  import ecd_pkg::*;
(
  // fetch port
  input wire logic [`ECD_PC_W-1:0] pm_addr,
  output ecd_word_s pm_word
);
  ecd_word_s mem [0:4095];

  // same-cycle answer: the core decodes the word on the very next edge
  assign pm_word = mem[pm_addr];

  initial begin
    for (int i = 0; i < 4096; i++) begin
      mem[i] = 16'h0000;
    end
  end
endmodule

`default_nettype wire

// ===== test/ecd_core_tb.sv
// self-checking bench of the engine control datapath core
// assumes ecd_pm_model as program memory and ecd_defs.svh on the include path
`timescale 1ns/100ps
`default_nettype none
`include "ecd_defs.svh"

module ecd_core_tb import ecd_pkg::*;;
  // ----------------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------------
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic sensor_ser_in = 1'b1;
  logic cmd_ser_in = 1'b0;
  logic ad_done_in = 1'b0;
  logic [`ECD_PC_W-1:0] pm_addr;
  ecd_word_s pm_word;
  logic pc_adv;
  logic ad_start;
  logic ser_shift;
  logic [3:0] ser_bit_idx;
  ecd_data_t da_out;
  logic [`ECD_OUTC_W-1:0] out_addr;
  logic [`ECD_INC_W-1:0] in_cnt;
  ecd_data_t acc_q;
  ecd_data_t mq_q;
  ecd_instr_e cur_instr;
  int failures = 0;
  int tests_run = 0;
  int cycles = 0;
  int advs = 0;
  int sers = 0;
  int idx_bad = 0;

  ecd_core ecd_core_inst (
    .sys_clk(sys_clk), .rst(rst), .ce(ce), .pm_addr(pm_addr), .pm_word(pm_word),
    .sensor_ser_in(sensor_ser_in), .cmd_ser_in(cmd_ser_in), .ad_done_in(ad_done_in),
    .pc_adv(pc_adv), .ad_start(ad_start), .ser_shift(ser_shift),
    .ser_bit_idx(ser_bit_idx), .da_out(da_out), .out_addr(out_addr), .in_cnt(in_cnt),
    .acc_q(acc_q), .mq_q(mq_q), .cur_instr(cur_instr)
  );

  ecd_pm_model ecd_pm_model_inst (.pm_addr(pm_addr), .pm_word(pm_word));

  // ----------------------------------------------------------------------
  // clock, pulse counters, hang guard
  // ----------------------------------------------------------------------
  always #25 sys_clk = ~sys_clk;

  // whole run needs well under a thousand cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (rst === 1'b1) begin
      advs = 0;
      sers = 0;
    end else begin
      if (pc_adv === 1'b1) advs++;
      // bit index must run 0..11 within each burst
      if (ser_shift === 1'b1) begin
        if (ser_bit_idx !== 4'(sers % 12)) idx_bad++;
        sers++;
      end
    end
    if (cycles == 2000) begin
      failures++;
      give_verdict();
    end
  end

  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task chk(input logic [11:0] got, input logic [11:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task do_reset;
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
  endtask

  // bounded wait for the fetch address, sampled mid-cycle
  task run_to(input logic [11:0] a);
    int n;
    n = 0;
    @(negedge sys_clk);
    while (pm_addr !== a && n < 400) begin
      @(negedge sys_clk);
      n++;
    end
    chk(pm_addr, a, "fetch address");
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task t_arith;
    logic [15:0] prog [0:8];
    logic [11:0] exp [0:8];
    prog = '{16'h3123, 16'h8005, 16'h3456, 16'h5905, 16'h0001,
             16'h7a05, 16'h5305, 16'h5c05, 16'h5605};
    exp = '{12'h123, 12'h123, 12'h456, 12'h579, 12'h579,
            12'h123, 12'hfff, 12'hffe, 12'heda};
    for (int i = 0; i < 9; i++) begin
      ecd_pm_model_inst.mem[i] = prog[i];
    end
    do_reset();
    for (int i = 0; i < 9; i++) begin
      run_to(12'(i + 1));
      chk(acc_q, exp[i], "acc after step");
      if (i == 4) chk(da_out, 12'h579, "output register");
    end
    chk(advs[11:0], 12'h009, "advance pulses");
    $display("test arith done");
  endtask

  task t_shift;
    ecd_pm_model_inst.mem[0] = 16'h4801;
    ecd_pm_model_inst.mem[1] = 16'h3003;
    ecd_pm_model_inst.mem[2] = 16'h9000;
    ecd_pm_model_inst.mem[3] = 16'ha000;
    do_reset();
    run_to(12'h001);
    chk(acc_q, 12'h000, "acc zeroed by mq load");
    chk(mq_q, 12'h801, "mq constant");
    run_to(12'h002);
    chk(acc_q, 12'h003, "acc constant");
    // freeze with ce low: nothing may advance
    @(posedge sys_clk);
    ce <= 1'b0;
    repeat (5) @(posedge sys_clk);
    ce <= 1'b1;
    @(negedge sys_clk);
    chk(pm_addr, 12'h002, "address frozen");
    run_to(12'h003);
    chk(acc_q, 12'h007, "acc rotate left");
    chk(mq_q, 12'h002, "mq rotate left");
    run_to(12'h004);
    chk(acc_q, 12'h003, "acc rotate right");
    chk(mq_q, 12'h801, "mq rotate right");
    $display("test shift done");
  endtask

  task t_io;
    logic [15:0] prog [0:7];
    prog = '{16'h0000, 16'h0000, 16'h1000, 16'h2000,
             16'h0002, 16'h0006, 16'h000e, 16'h000f};
    for (int i = 0; i < 8; i++) begin
      ecd_pm_model_inst.mem[i] = prog[i];
    end
    do_reset();
    // leading nops let the pin synchronisers settle before sampling
    @(posedge sys_clk);
    ad_done_in <= 1'b1;
    repeat (8) @(posedge sys_clk);
    ad_done_in <= 1'b0;
    run_to(12'h003);
    chk(acc_q, 12'hfff, "sensor serial in");
    chk(sers[11:0], 12'h00c, "burst length");
    run_to(12'h004);
    chk(acc_q, 12'h000, "command serial in");
    run_to(12'h006);
    chk({11'h000, ad_start}, 12'h001, "converter start");
    chk({8'h00, cur_instr}, {8'h00, ecd_i_out_ad}, "decode out 14");
    chk({9'h000, out_addr}, 12'h002, "output address count");
    chk({7'h00, in_cnt}, 12'h001, "input count");
    run_to(12'h007);
    chk({8'h00, cur_instr}, {8'h00, ecd_i_restart}, "decode out 15");
    @(negedge sys_clk);
    chk(pm_addr, 12'h000, "restart address");
    chk({9'h000, out_addr}, 12'h000, "restart output count");
    chk({7'h00, in_cnt}, 12'h000, "restart input count");
    chk(advs[11:0], 12'h007, "no advance on restart");
    chk(idx_bad[11:0], 12'h000, "serial bit index");
    $display("test io done");
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    // let the memory model clear itself before the first program lands
    @(negedge sys_clk);
    t_arith();
    t_shift();
    t_io();
    give_verdict();
  end
endmodule

`default_nettype wire
